//--- logic/codec_serial_audio_slave.v
/*
 Slave end of the capture and playback serial audio links.
 Assumes the codec drives both bit clocks and frame syncs; the
 bit clocks are sampled by clk at 250 MHz and edges found here.
 Each bit clock level must span several clk periods or edges are lost.
*/
// Contract
// - Codec clocks playback; we drive data
// - Sample capture data on rising edge
// - Update playback data on falling edge
// - Tolerate one bit clock frame jitter
// - Selectable pulse or I2S framing, both links
// - Pulse: start one bit late, left then right
// - Pulse: right follows left, 16-bit words
// - I2S word starts one bit after edge
// - I2S: right after rise, left after fall
// - I2S: 16-bit words, then zeros
// - Never drive bit clock or sync
`timescale 1ns/1ns
`include "serial_audio_regs.vh"
module codec_serial_audio_slave #(
    parameter WORD = `WORD_BITS,
    parameter DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Format select
    input wire serial_format_control,
    // Capture link, all inputs
    input wire capture_bit_clock,
    input wire capture_frame_sync,
    input wire capture_serial_line,
    // Playback link
    input wire playback_bit_clock,
    input wire playback_frame_sync,
    output reg playback_serial_line,
    // Capture samples out
    output reg capture_valid,
    output reg [WORD-1:0] capture_sample,
    // Playback samples in, left high half
    input wire play_valid,
    output wire play_ready,
    input wire [2*WORD-1:0] play_data,
    // Playback underrun marker
    output reg play_underrun
);
    // ----------------------------------------
    // Local sizes
    // ----------------------------------------
    // Slot length at the bit counter's width, so subtraction stays narrow
    localparam [`BITPOS_W-1:0] WORD_POS = WORD;
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Both bit clocks and syncs are outputs of the codec only
    reg [2:0] cap_s1;
    reg [2:0] cap_s2;
    reg [1:0] ply_s1;
    reg [1:0] ply_s2;
    reg cap_clk_d;
    reg ply_clk_d;
    reg cap_sync_d;
    reg ply_sync_d;
    reg fmt;
    reg [1:0] warm;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cap_s1 <= 3'h0;
            cap_s2 <= 3'h0;
            ply_s1 <= 2'h0;
            ply_s2 <= 2'h0;
            cap_clk_d <= 1'b0;
            ply_clk_d <= 1'b0;
            warm <= 2'h0;
        end else begin
            cap_s1 <= {capture_bit_clock, capture_frame_sync, capture_serial_line};
            cap_s2 <= cap_s1;
            ply_s1 <= {playback_bit_clock, playback_frame_sync};
            ply_s2 <= ply_s1;
            cap_clk_d <= cap_s2[2];
            ply_clk_d <= ply_s2[1];
            if (warm != 2'h3) begin
                warm <= warm + 2'h1;
            end
        end
    end
    // Edge detectors reset low, but a bit clock may idle high
    // Ignore edges until the delay line holds real pin levels
    wire edges_armed = (warm == 2'h3);
    wire cap_rise = cap_s2[2] && !cap_clk_d && edges_armed;
    wire ply_fall = !ply_s2[1] && ply_clk_d && edges_armed;
    // ----------------------------------------
    // Capture receiver
    // ----------------------------------------
    reg [`BITPOS_W-1:0] cap_pos;
    reg [WORD-1:0] cap_shift;
    wire cap_sync = cap_s2[1];
    // Counters saturate, so a lost sync leaves the receiver idle
    wire cap_pulse_start = (fmt == `FMT_PULSE) && cap_sync && !cap_sync_d;
    // Only the slot after the sync rise is kept (left in pulse, right in I2S), the other is the same sample
    wire cap_restart = cap_pulse_start || ((fmt == `FMT_I2S) && cap_sync && !cap_sync_d);
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cap_pos <= {`BITPOS_W{1'b1}};
            cap_shift <= {WORD{1'b0}};
            cap_sync_d <= 1'b0;
            capture_valid <= 1'b0;
            capture_sample <= {WORD{1'b0}};
            fmt <= `FMT_PULSE;
        end else begin
            capture_valid <= 1'b0;
            if (cap_rise) begin
                cap_sync_d <= cap_sync;
                // Format changes only between frames to avoid a torn word
                if (cap_restart) begin
                    fmt <= serial_format_control;
                end
                if (cap_restart) begin
                    cap_pos <= {`BITPOS_W{1'b0}};
                end else if (cap_pos != {`BITPOS_W{1'b1}}) begin
                    cap_pos <= cap_pos + 1'b1;
                end
                if (cap_pos < WORD) begin
                    cap_shift <= {cap_shift[WORD-2:0], cap_s2[0]};
                end
                if (cap_pos == WORD) begin
                    capture_valid <= 1'b1;
                    capture_sample <= cap_shift;
                end
            end
        end
    end
    // ----------------------------------------
    // Playback FIFO
    // ----------------------------------------
    wire fifo_valid;
    wire [2*WORD-1:0] fifo_data;
    reg fifo_take;
    sample_fifo #(
        .WIDTH(2*WORD),
        .DEPTH(DEPTH),
        .AW(5)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(play_valid),
        .in_ready(play_ready),
        .in_data(play_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );
    // ----------------------------------------
    // Playback transmitter
    // ----------------------------------------
    reg [`BITPOS_W-1:0] ply_pos;
    reg [WORD-1:0] ply_left;
    reg [WORD-1:0] ply_right;
    wire ply_sync = ply_s2[0];
    wire ply_rise = ply_sync && !ply_sync_d;
    wire ply_sfall = !ply_sync && ply_sync_d;
    reg [WORD-1:0] next_word;
    // Bit index within current slot, and slot selection
    wire [`BITPOS_W-1:0] slot_pos = (ply_pos >= WORD_POS) ? ply_pos - WORD_POS : ply_pos;
    always @* begin
        next_word = {WORD{1'b0}};
        if (fmt == `FMT_PULSE) begin
            next_word = (ply_pos < WORD) ? ply_left : ply_right;
        end else begin
            next_word = ply_sync ? ply_right : ply_left;
        end
    end
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ply_pos <= {`BITPOS_W{1'b1}};
            ply_left <= {WORD{1'b0}};
            ply_right <= {WORD{1'b0}};
            ply_sync_d <= 1'b0;
            playback_serial_line <= 1'b0;
            fifo_take <= 1'b0;
            play_underrun <= 1'b0;
        end else begin
            fifo_take <= 1'b0;
            play_underrun <= 1'b0;
            if (ply_fall) begin
                ply_sync_d <= ply_sync;
                // Frame start loads a fresh pair; silence on underrun
                // Zeros rather than the last pair, so a gap is heard as one
                if (ply_rise) begin
                    ply_pos <= {`BITPOS_W{1'b0}};
                    ply_left <= fifo_valid ? fifo_data[2*WORD-1:WORD] : {WORD{1'b0}};
                    ply_right <= fifo_valid ? fifo_data[WORD-1:0] : {WORD{1'b0}};
                    fifo_take <= fifo_valid;
                    play_underrun <= !fifo_valid;
                    playback_serial_line <= 1'b0;
                end else if (ply_sfall && fmt == `FMT_I2S) begin
                    ply_pos <= {`BITPOS_W{1'b0}};
                    playback_serial_line <= 1'b0;
                end else begin
                    if (ply_pos != {`BITPOS_W{1'b1}}) begin
                        ply_pos <= ply_pos + 1'b1;
                    end
                    if (fmt == `FMT_PULSE && ply_pos < 2*WORD) begin
                        playback_serial_line <= next_word[WORD-1-slot_pos[3:0]];
                    end else if (fmt == `FMT_I2S && ply_pos < WORD) begin
                        playback_serial_line <= next_word[WORD-1-ply_pos[3:0]];
                    end else begin
                        playback_serial_line <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

//--- inc/serial_audio_regs.vh
/*
 Timing counts and format codes for the serial audio slave.
 Assumes inclusion by bare name from design files.
*/
`ifndef SERIAL_AUDIO_REGS_VH
`define SERIAL_AUDIO_REGS_VH
`define WORD_BITS 16
`define SYNC_HIGH_BITS 32
`define FMT_PULSE 1'b0
`define FMT_I2S 1'b1
`define FIFO_DEPTH 32
`define BITPOS_W 7
`endif

//--- logic/sample_fifo.v
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module sample_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    localparam [AW:0] DEPTH_W = DEPTH;
    reg ready_q;
    wire [AW:0] count = wr_ptr - rd_ptr;
    wire empty = (count == {(AW+1){1'b0}});
    wire pop = !empty && (!out_valid || out_ready);
    wire push = in_valid && in_ready;
    wire leave = out_valid && out_ready;
    // Fill level counts the prefetched word too, so DEPTH words in all
    wire [AW:0] occ = count + {{AW{1'b0}}, out_valid};
    wire [AW:0] next_occ = occ + {{AW{1'b0}}, push} - {{AW{1'b0}}, leave};
    // Ready from a register, so it reaches the top port from a flop
    assign in_ready = ready_q;
    always @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    // Read data comes from a register, one word prefetched
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
            ready_q <= 1'b1;
        end else begin
            ready_q <= (next_occ < DEPTH_W);
            if (in_valid && in_ready) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                out_data <= mem[rd_ptr[AW-1:0]];
                rd_ptr <= rd_ptr + 1'b1;
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

//--- bench/codec_serial_audio_slave_asserts.sv
/* Port checker for the serial audio slave.
   Assumes binding to every instance of the top module. */
`timescale 1ns/1ns
module codec_serial_audio_slave_asserts #(
    parameter WORD = 16
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Link pins
    input wire capture_bit_clock,
    input wire playback_bit_clock,
    input wire playback_serial_line,
    // User side
    input wire capture_valid,
    input wire [WORD-1:0] capture_sample,
    input wire play_valid,
    input wire play_ready,
    input wire play_underrun
);
    // ----------------
    // Properties
    // ----------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_line_on_fall: assert property (
        $changed(playback_serial_line) |-> !playback_bit_clock) else $error("Line moved high");
    chk_line_at_rise: assert property (
        $rose(playback_bit_clock) |-> $stable(playback_serial_line)[*6]) else $error("Line unstable");
    chk_capture_rise: assert property (
        capture_valid |-> capture_bit_clock) else $error("Capture not after rise");
    chk_capture_pulse: assert property (
        capture_valid |=> !capture_valid) else $error("Capture pulse too long");
    chk_sample_holds: assert property (
        $changed(capture_sample) |-> capture_valid) else $error("Sample moved alone");
    chk_underrun_pulse: assert property (
        play_underrun |=> !play_underrun) else $error("Underrun pulse too long");
    chk_underrun_zero: assert property (
        play_underrun |=> (!playback_serial_line)[*8]) else $error("Underrun not zero");
    chk_ready_falls: assert property (
        $fell(play_ready) |-> $past(play_valid)) else $error("Ready fell without push");
endmodule
bind codec_serial_audio_slave codec_serial_audio_slave_asserts #(.WORD(WORD)) chk (
    .clk(clk), .nrst(nrst), .capture_bit_clock(capture_bit_clock),
    .playback_bit_clock(playback_bit_clock), .playback_serial_line(playback_serial_line),
    .capture_valid(capture_valid), .capture_sample(capture_sample),
    .play_valid(play_valid), .play_ready(play_ready), .play_underrun(play_underrun));

//--- bench/codec_master_model.sv
/* Codec side of both links: bit clock, sync, capture data.
   Assumes fmt and cap_word change only between frames. */
`timescale 1ns/1ns
module codec_master_model (
    // Control
    input wire run,
    input wire fmt,
    input wire [15:0] cap_word,
    // Link pins
    output logic bclk,
    output logic sync,
    output logic cap_line,
    input wire play_line,
    // Received pair, left high
    output logic [31:0] rx_pair,
    output int frames,
    output int stray
);
    // ----------------
    // Frame engine
    // ----------------
    int b, len, i;
    logic f;
    logic [15:0] w;
    function automatic int slot(input int p, input logic m);
        if (!m) return (p >= 1 && p <= 32) ? p - 1 : -1;
        if (p >= 1 && p <= 16) return p + 15;
        return (p >= 33 && p <= 48) ? p - 33 : -1;
    endfunction
    initial begin
        {bclk, sync, cap_line, rx_pair, frames, len, stray} = 0;
        // Rests high, so the first frame opens on a falling edge
        bclk = 1;
        forever begin
            // Clock stands still between bursts
            while (!run) #10;
            len = (len == 68) ? 69 : 68;
            f = fmt;
            w = cap_word;
            for (b = 0; b < len; b++) begin
                #80 bclk = 0;
                sync = f ? (b < 32) : (b == 0);
                i = slot(b, f);
                cap_line = (i >= 0) ? w[15 - i % 16] : (f ? 1'b0 : ~cap_line);
                #80 bclk = 1;
                if (i >= 0) rx_pair[31 - i] = play_line;
                else if (f && play_line !== 1'b0) stray++;
            end
            frames++;
        end
    end
endmodule

//--- bench/tb_codec_serial_audio_slave.sv
/* Self-checking bench: codec model on both links, FIFO fill and drain.
   Assumes the design and the codec model compile alongside. */
`timescale 1ns/1ns
module tb_codec_serial_audio_slave;
    logic clk = 0, nrst = 0, fmt = 0, run = 0, play_valid = 0;
    logic [31:0] play_data = 0, lfsr = 32'h8f6e;
    logic [15:0] cap_word = 0;
    wire bclk, sync, cap_line, pline, cvalid, pready, punder;
    wire [15:0] csample;
    wire [31:0] rx_pair;
    int frames, n, failures = 0, total_checks = 0, ncap = 0, nund = 0, stray;
    logic [31:0] q[$];
    // ----------------
    // Structure
    // ----------------
    codec_serial_audio_slave #(.WORD(16), .DEPTH(32)) uut (.clk(clk), .nrst(nrst),
        .serial_format_control(fmt), .capture_bit_clock(bclk), .capture_frame_sync(sync),
        .capture_serial_line(cap_line), .playback_bit_clock(bclk), .playback_frame_sync(sync),
        .playback_serial_line(pline), .capture_valid(cvalid), .capture_sample(csample),
        .play_valid(play_valid), .play_ready(pready), .play_data(play_data),
        .play_underrun(punder));
    codec_master_model cm (.run(run), .fmt(fmt), .cap_word(cap_word), .bclk(bclk),
        .sync(sync), .cap_line(cap_line), .play_line(pline), .rx_pair(rx_pair),
        .frames(frames), .stray(stray));
    initial forever #2 clk = ~clk;
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        if (cvalid === 1'b1) begin
            ncap++;
            check({16'h0, csample}, {16'h0, cm.w});
        end
        if (punder === 1'b1) nund++;
    end
    // Offer words for up to 40 cycles or until want are taken; ready is sampled at the accepting edge
    task automatic fill(input int want);
        n = 0;
        play_data <= lfsr;
        play_valid <= 1;
        for (int k = 0; k < 40 && n < want; k++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                q.push_back(play_data);
                n++;
                lfsr = next_rand(lfsr);
                play_data <= lfsr;
            end
        end
        play_valid <= 0;
        $display("Fill done, %0d words taken", n);
    endtask
    task automatic run_frames(input int cnt, input logic f, input int und);
        fmt <= f;
        ncap = 0;
        nund = 0;
        @(posedge clk) run <= 1;
        for (int k = 0; k < cnt; k++) begin
            lfsr = next_rand(lfsr);
            cap_word <= lfsr[15:0];
            if (k == cnt - 1) run <= 0;
            n = frames;
            for (int t = 0; t < 4000 && frames == n; t++) @(posedge clk);
            if (frames == n) begin
                failures++;
                wrap_up;
            end
            check(rx_pair, q.size() ? q.pop_front() : 32'h0);
        end
        @(posedge clk);
        check(32'(ncap), 32'(cnt));
        check(32'(nund), 32'(und));
        check(32'(stray), 32'h0);
        $display("Burst done, format %0d", f);
    endtask
    // ----------------
    // Sequence
    // ----------------
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        fill(40);
        check(32'(n), 32'h20);
        check({31'h0, pready}, 32'h0);
        run_frames(20, 1'b0, 0);
        run_frames(14, 1'b1, 2);
        wrap_up;
    end
endmodule
